/* breaker_object_defines.vh */
/*
  Constants for the breaker object control block: APB offsets, field
  positions, reset values and timing counts. Assumes a 25 MHz system clock.
*/
`ifndef BREAKER_OBJECT_DEFINES_VH
`define BREAKER_OBJECT_DEFINES_VH

// Timing
`define BOC_CLK_FREQ_HZ     25000000
`define BOC_TICK_MS         1
`define BOC_MS_CYCLES       ((`BOC_CLK_FREQ_HZ / 1000) * `BOC_TICK_MS)
`define BOC_TRAVERSE_MS     16'h00c8
`define BOC_PULSE_MS        16'h00c8
`define BOC_TERMINATE_MS    16'h2710

// Register byte offsets
`define BOC_CTRL_OFS        8'h00
`define BOC_PULSE_OFS       8'h04
`define BOC_TIMES_OFS       8'h08
`define BOC_CMD_OFS         8'h0c
`define BOC_GROUP_OFS       8'h10
`define BOC_STATUS_OFS      8'h14
`define BOC_OPEN_CNT_OFS    8'h18
`define BOC_CLOSE_CNT_OFS   8'h1c

// Control register fields
`define BOC_CTRL_ENABLE     0
`define BOC_CTRL_REMOTE     1
`define BOC_CTRL_USE_SYNC   2
`define BOC_CTRL_USE_READY  3
`define BOC_CTRL_WITHDRAW   4
`define BOC_CTRL_FORCE_OK   5
`define BOC_CTRL_REM_GRP_OK 6
`define BOC_CTRL_STATIC     7
`define BOC_CTRL_RESET      8'h00

// Command register fields (write only, self clearing)
`define BOC_CMD_OPEN        0
`define BOC_CMD_CLOSE       1
`define BOC_CMD_CLEAR       2
`define BOC_CMD_REM_GRP     3
`define BOC_CMD_FORCE_GRP   4
`define BOC_CMD_CLR_FAIL    5
`define BOC_CMD_GRP_LSB     8

// Group register fields
`define BOC_GRP_USED_LSB    0
`define BOC_GRP_MASK_LSB    8
`define BOC_GRP_USED_RESET  8'h01
`define BOC_GRP_MASK_RESET  8'h00

// Object status codes
`define BOC_ST_INTER        2'h0
`define BOC_ST_OPEN         2'h1
`define BOC_ST_CLOSED       2'h2
`define BOC_ST_BAD          2'h3

`endif

/* breaker_object_control.v */
/*
  Breaker object control: status decode, bounded open/close command pulses,
  failure supervision, statistics and eight-way setting group selection,
  with an APB register slave. Assumes status and request pins are
  asynchronous to clk and are synchronised here.
*/
// The register offsets and the APB interface to the registers were decided locally.
// Function
// - Both status inputs low means object intermediate.
// - Both status inputs high, object or cart, means status bad.
// - Local access refuses bus commands; remote access refuses local inputs.
// - Close issued only with active permission when sync or ready check used.
// - Separate counters for open and close requests.
// - Separate failure counters when status does not change after request.
// - Command pulse bounded by maximum length, cut short on status change.
// - No status change within termination timeout records a failed event.
// - On that timeout the operation is abandoned and failure raised.
// - Intermediate tolerated up to traverse time before being reported.
// - Application requests act regardless of local/remote selector.
// - Highest priority requested group wins; group one highest.
// - Forced group selection honoured only while force permit set.
// - Remote group change accepted only while remote change enabled.
// - Groups selectable by pulses alone or by pulses plus static levels.
// - Each group enabled individually (code holds group one always enabled); only group one enabled after reset.
// - Group event masks reset off; only masked events are reported.
// - Object resets disabled and operates only once enabled.
// - Clear statistics zeroes request and failure counters.
`include "breaker_object_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module breaker_object_control #(
  parameter MS_CYCLES = `BOC_MS_CYCLES,
  parameter CNT_W     = 16
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Object status pins
  input  wire        obj_open_in,
  input  wire        obj_close_in,
  input  wire        cart_in_in,
  input  wire        cart_out_in,
  input  wire        ready_in,
  input  wire        sync_ok_in,
  // Control request pins
  input  wire        local_open_in,
  input  wire        local_close_in,
  input  wire        remote_open_in,
  input  wire        remote_close_in,
  input  wire        app_open_in,
  input  wire        app_close_in,
  // Setting group request pins
  input  wire [7:0]  group_pulse_in,
  input  wire [7:0]  group_level_in,
  // Object outputs
  output reg         open_cmd,
  output reg         close_cmd,
  output reg         fail_flag,
  output reg  [1:0]  obj_status,
  output reg  [1:0]  cart_status,
  // Setting group outputs
  output reg  [2:0]  setting_group_index,
  output reg         group_event,
  output reg  [2:0]  group_event_index
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_PULSE = 3'b010;
  localparam ST_WAIT  = 3'b100;
  // Pin synchronisers
  wire [27:0] pins_raw = {group_level_in, group_pulse_in, app_close_in, app_open_in,
                          remote_close_in, remote_open_in, local_close_in,
                          local_open_in, sync_ok_in, ready_in, cart_out_in,
                          cart_in_in, obj_close_in, obj_open_in};
  reg  [27:0] sync1_reg;
  reg  [27:0] sync2_reg;
  reg  [27:0] prev_reg;
  always @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= 28'h0000000;
      sync2_reg <= 28'h0000000;
      prev_reg  <= 28'h0000000;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end
  wire [27:0] rise = sync2_reg & ~prev_reg;

  // Settings
  reg [7:0]       ctrl_reg;
  reg [15:0]      open_len_reg;
  reg [15:0]      close_len_reg;
  reg [15:0]      traverse_reg;
  reg [15:0]      terminate_reg;
  reg [7:0]       group_used_reg;
  reg [7:0]       group_mask_reg;
  reg [CNT_W-1:0] open_req_cnt_reg;
  reg [CNT_W-1:0] open_fail_cnt_reg;
  reg [CNT_W-1:0] close_req_cnt_reg;
  reg [CNT_W-1:0] close_fail_cnt_reg;

  // APB decode; the write lands at the edge where pready is sampled high
  wire        acc      = psel & penable & pready;
  wire        wr       = acc & pwrite;
  wire        cmd_wr   = wr & (paddr == `BOC_CMD_OFS);
  wire [2:0]  cmd_grp  = pwdata[`BOC_CMD_GRP_LSB+2:`BOC_CMD_GRP_LSB];
  wire        clear_st = cmd_wr & pwdata[`BOC_CMD_CLEAR];
  wire        mapped   = (paddr[1:0] == 2'h0) && (paddr <= `BOC_CLOSE_CNT_OFS);

  // Millisecond tick
  reg  [15:0] tick_cnt_reg;
  wire        ms_tick = (tick_cnt_reg == MS_CYCLES - 1);
  always @(posedge clk) begin
    if (sys_rst)
      tick_cnt_reg <= 16'h0000;
    else if (ms_tick)
      tick_cnt_reg <= 16'h0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
  end

  // Status decode
  wire [1:0] raw_status  = {sync2_reg[1], sync2_reg[0]};
  wire [1:0] cart_raw    = {sync2_reg[3], sync2_reg[2]};
  reg  [15:0] trav_cnt_reg;
  always @(posedge clk) begin
    if (sys_rst) begin
      trav_cnt_reg <= 16'h0000;
      obj_status   <= `BOC_ST_INTER;
      cart_status  <= `BOC_ST_INTER;
    end else begin
      if (raw_status != `BOC_ST_INTER)
        trav_cnt_reg <= 16'h0000;
      else if (ms_tick && trav_cnt_reg != 16'hffff)
        trav_cnt_reg <= trav_cnt_reg + 16'h0001;
      // Previous status stands while the contacts travel
      if (raw_status != `BOC_ST_INTER || trav_cnt_reg >= traverse_reg)
        obj_status <= raw_status;
      // Cart reports in/out as open/closed; absent cart reads intermediate
      if (ctrl_reg[`BOC_CTRL_WITHDRAW])
        cart_status <= cart_raw;
      else
        cart_status <= `BOC_ST_INTER;
    end
  end

  // Request arbitration
  wire remote   = ctrl_reg[`BOC_CTRL_REMOTE];
  wire bus_open = cmd_wr & pwdata[`BOC_CMD_OPEN];
  wire bus_cls  = cmd_wr & pwdata[`BOC_CMD_CLOSE];
  wire req_open = rise[10] |
                  (~remote & rise[6]) |
                  (remote & (rise[8] | bus_open));
  wire req_cls  = rise[11] |
                  (~remote & rise[7]) |
                  (remote & (rise[9] | bus_cls));
  wire close_ok = (~ctrl_reg[`BOC_CTRL_USE_SYNC] | sync2_reg[5]) &
                  (~ctrl_reg[`BOC_CTRL_USE_READY] | sync2_reg[4]);
  reg  [2:0]  state_reg;
  reg         dir_close_reg;
  reg  [1:0]  start_status_reg;
  reg  [15:0] op_cnt_reg;
  wire        enabled   = ctrl_reg[`BOC_CTRL_ENABLE];
  wire [15:0] pulse_len = dir_close_reg ? close_len_reg : open_len_reg;
  wire [1:0]  target    = dir_close_reg ? `BOC_ST_CLOSED : `BOC_ST_OPEN;
  wire        take_open = enabled & (state_reg == ST_IDLE) & req_open;
  wire        take_cls  = enabled & (state_reg == ST_IDLE) & ~req_open &
                          req_cls & close_ok;
  wire        timed_out = (state_reg != ST_IDLE) && (op_cnt_reg >= terminate_reg) &&
                          (obj_status != target);
  wire        fail_set  = timed_out;
  wire        fail_clr  = cmd_wr & pwdata[`BOC_CMD_CLR_FAIL];
  always @(posedge clk) begin
    if (sys_rst) begin
      state_reg        <= ST_IDLE;
      dir_close_reg    <= 1'b0;
      start_status_reg <= `BOC_ST_INTER;
      op_cnt_reg       <= 16'h0000;
      open_cmd         <= 1'b0;
      close_cmd        <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          op_cnt_reg <= 16'h0000;
          if (take_open | take_cls) begin
            state_reg        <= ST_PULSE;
            dir_close_reg    <= take_cls;
            start_status_reg <= obj_status;
            open_cmd         <= take_open;
            close_cmd        <= take_cls;
          end
        end
        ST_PULSE: begin
          if (ms_tick)
            op_cnt_reg <= op_cnt_reg + 16'h0001;
          if (timed_out) begin
            state_reg <= ST_IDLE;
            open_cmd  <= 1'b0;
            close_cmd <= 1'b0;
          end else if (obj_status != start_status_reg || op_cnt_reg >= pulse_len) begin
            state_reg <= ST_WAIT;
            open_cmd  <= 1'b0;
            close_cmd <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (ms_tick)
            op_cnt_reg <= op_cnt_reg + 16'h0001;
          if (obj_status == target || timed_out)
            state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
          open_cmd  <= 1'b0;
          close_cmd <= 1'b0;
        end
      endcase
    end
  end

  // Statistics and failure flag
  always @(posedge clk) begin
    if (sys_rst) begin
      open_req_cnt_reg   <= {CNT_W{1'b0}};
      close_req_cnt_reg  <= {CNT_W{1'b0}};
      open_fail_cnt_reg  <= {CNT_W{1'b0}};
      close_fail_cnt_reg <= {CNT_W{1'b0}};
      fail_flag          <= 1'b0;
    end else begin
      if (clear_st) begin
        open_req_cnt_reg   <= {CNT_W{1'b0}};
        close_req_cnt_reg  <= {CNT_W{1'b0}};
        open_fail_cnt_reg  <= {CNT_W{1'b0}};
        close_fail_cnt_reg <= {CNT_W{1'b0}};
      end else begin
        if (take_open)
          open_req_cnt_reg <= open_req_cnt_reg + 1'b1;
        if (take_cls)
          close_req_cnt_reg <= close_req_cnt_reg + 1'b1;
        if (fail_set && !dir_close_reg)
          open_fail_cnt_reg <= open_fail_cnt_reg + 1'b1;
        if (fail_set && dir_close_reg)
          close_fail_cnt_reg <= close_fail_cnt_reg + 1'b1;
      end
      // Set wins over a clear in the same cycle
      if (fail_set)
        fail_flag <= 1'b1;
      else if (fail_clr)
        fail_flag <= 1'b0;
    end
  end

  // Setting group selection
  wire       force_req = cmd_wr & pwdata[`BOC_CMD_FORCE_GRP] & ctrl_reg[`BOC_CTRL_FORCE_OK];
  wire       rem_req   = cmd_wr & pwdata[`BOC_CMD_REM_GRP] & ctrl_reg[`BOC_CTRL_REM_GRP_OK];
  wire [7:0] grp_req;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : grp_src
      assign grp_req[g] = group_used_reg[g] & (
                          rise[12+g] |
                          (ctrl_reg[`BOC_CTRL_STATIC] & sync2_reg[20+g]) |
                          (force_req & (cmd_grp == g)) |
                          (rem_req & (cmd_grp == g)));
    end
  endgenerate

  reg [2:0] grp_win;
  integer   k;
  always @* begin
    grp_win = 3'h0;
    for (k = 7; k >= 0; k = k - 1)
      if (grp_req[k])
        grp_win = k[2:0];
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      setting_group_index <= 3'h0;
      group_event         <= 1'b0;
      group_event_index   <= 3'h0;
    end else begin
      group_event <= 1'b0;
      if (|grp_req && grp_win != setting_group_index) begin
        setting_group_index <= grp_win;
        group_event         <= group_mask_reg[grp_win];
        group_event_index   <= grp_win;
      end
    end
  end

  // Register writes
  always @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg       <= `BOC_CTRL_RESET;
      open_len_reg   <= `BOC_PULSE_MS;
      close_len_reg  <= `BOC_PULSE_MS;
      traverse_reg   <= `BOC_TRAVERSE_MS;
      terminate_reg  <= `BOC_TERMINATE_MS;
      group_used_reg <= `BOC_GRP_USED_RESET;
      group_mask_reg <= `BOC_GRP_MASK_RESET;
    end else if (wr) begin
      case (paddr)
        `BOC_CTRL_OFS:  ctrl_reg <= pwdata[7:0];
        `BOC_PULSE_OFS: begin
          open_len_reg  <= pwdata[15:0];
          close_len_reg <= pwdata[31:16];
        end
        `BOC_TIMES_OFS: begin
          traverse_reg  <= pwdata[15:0];
          terminate_reg <= pwdata[31:16];
        end
        `BOC_GROUP_OFS: begin
          // Group one cannot be switched off, so one group always remains usable
          group_used_reg <= pwdata[`BOC_GRP_USED_LSB+7:`BOC_GRP_USED_LSB] | 8'h01;
          group_mask_reg <= pwdata[`BOC_GRP_MASK_LSB+7:`BOC_GRP_MASK_LSB];
        end
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Read mux
  reg [31:0] rd_data;
  always @* begin
    case (paddr)
      `BOC_CTRL_OFS:      rd_data = {24'h000000, ctrl_reg};
      `BOC_PULSE_OFS:     rd_data = {close_len_reg, open_len_reg};
      `BOC_TIMES_OFS:     rd_data = {terminate_reg, traverse_reg};
      `BOC_GROUP_OFS:     rd_data = {16'h0000, group_mask_reg, group_used_reg};
      `BOC_STATUS_OFS:    rd_data = {20'h00000, close_cmd, open_cmd,
                                     setting_group_index, 1'b0,
                                     (state_reg != ST_IDLE), fail_flag,
                                     cart_status, obj_status};
      `BOC_OPEN_CNT_OFS:  rd_data = {open_fail_cnt_reg[15:0], open_req_cnt_reg[15:0]};
      `BOC_CLOSE_CNT_OFS: rd_data = {close_fail_cnt_reg[15:0], close_req_cnt_reg[15:0]};
      default:            rd_data = 32'h00000000;
    endcase
  end

  // One wait state per access keeps read data registered
  always @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rd_data;
    end
  end

endmodule // breaker_object_control
`default_nettype wire

/* breaker_object_control_assertions.sv */
/*
  Port checker for breaker_object_control, attached by bind.
  Assumes the traverse time is set to two milliseconds or more.
*/
`include "breaker_object_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module breaker_object_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Object pins
  input wire logic       obj_open_in,
  input wire logic       obj_close_in,
  input wire logic       cart_in_in,
  input wire logic       cart_out_in,
  // Object outputs
  input wire logic       open_cmd,
  input wire logic       close_cmd,
  input wire logic       fail_flag,
  input wire logic [1:0] obj_status,
  input wire logic [1:0] cart_status,
  // Group outputs
  input wire logic [2:0] setting_group_index,
  input wire logic       group_event,
  input wire logic [2:0] group_event_index
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic [1:0] st0;
  // Status held from the last idle cycle, the start value of a command
  always @(posedge clk) begin
    if (sys_rst)
      st0 <= 2'h0;
    else if (!(open_cmd || close_cmd))
      st0 <= obj_status;
  end
  sequence s_moved;
    (open_cmd || close_cmd) && obj_status != st0;
  endsequence
  sequence s_to_inter;
    $changed(obj_status) && obj_status == `BOC_ST_INTER;
  endsequence
  a_pulse_cut_short: assert property (s_moved |=> !(open_cmd || close_cmd))
    else $error("command outlived a status change");
  a_cmd_no_overlap: assert property (!(open_cmd && close_cmd))
    else $error("open and close commands together");
  a_obj_bad_seen: assert property ((obj_open_in && obj_close_in) [*6] |->
    obj_status == `BOC_ST_BAD) else $error("object bad not reported");
  a_cart_bad_seen: assert property ((cart_in_in && cart_out_in) [*6] |->
    cart_status == `BOC_ST_BAD) else $error("cart bad not reported");
  a_inter_cause: assert property (s_to_inter |->
    $past(!obj_open_in && !obj_close_in, 3))
    else $error("intermediate without both contacts low");
  a_traverse_wait: assert property (s_to_inter |->
    $past(!obj_open_in && !obj_close_in, 5))
    else $error("intermediate reported before traverse time");
  a_event_index: assert property (group_event |->
    group_event_index == setting_group_index) else $error("event index mismatch");
  a_event_on_change: assert property (group_event |->
    setting_group_index != $past(setting_group_index)) else $error("event without change");
  a_reset_clears: assert property ($fell(sys_rst) |-> !open_cmd && !close_cmd
    && !fail_flag && setting_group_index == 3'h0) else $error("state after reset");
endmodule // breaker_object_checker
bind breaker_object_control breaker_object_checker u_breaker_object_checker (
  .clk(clk), .sys_rst(sys_rst), .obj_open_in(obj_open_in), .obj_close_in(obj_close_in),
  .cart_in_in(cart_in_in), .cart_out_in(cart_out_in), .open_cmd(open_cmd),
  .close_cmd(close_cmd), .fail_flag(fail_flag), .obj_status(obj_status),
  .cart_status(cart_status), .setting_group_index(setting_group_index),
  .group_event(group_event), .group_event_index(group_event_index));
`default_nettype wire

/* breaker_model.sv */
/*
  Behavioural circuit breaker with auxiliary contacts and a racked-in cart.
  Assumes command pulses come from the control block on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module breaker_model (
  // Clock and commands
  input  wire logic       clk,
  input  wire logic       open_cmd,
  input  wire logic       close_cmd,
  // Bench controls
  input  wire logic       stuck,
  input  wire logic       slow,
  input  wire logic [1:0] fault,
  // Contacts
  output logic            aux_open,
  output logic            aux_close,
  output logic            rack_in,
  output logic            rack_out
);
  logic closed_q = 1'b1;
  logic tgt      = 1'b1;
  int   mv       = 0;
  // Stuck mechanism ignores commands so supervision can time out
  always @(posedge clk) begin
    if (mv != 0) begin
      mv <= mv - 1;
      if (mv == 1) closed_q <= tgt;
    end else if (!stuck && (open_cmd ? closed_q : close_cmd && !closed_q)) begin
      tgt <= !open_cmd;
      mv  <= slow ? 40 : 5;
    end
  end
  // Both contacts open while travelling
  assign aux_open  = fault[0] | (mv == 0 && !closed_q);
  assign aux_close = fault[0] | (mv == 0 && closed_q);
  // Cart stays racked in; fault bit 1 raises the out contact too
  assign rack_in   = 1'b1;
  assign rack_out  = fault[1];
endmodule // breaker_model
`default_nettype wire

/* tb_breaker_object_control.sv */
/*
  Self-checking bench for breaker_object_control with a breaker model.
  Assumes MS_CYCLES of 4, so one millisecond is four clocks.
*/
`include "breaker_object_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_breaker_object_control;
  logic        clk, sys_rst, psel, penable, pwrite, er, rdy, stuck, slow, sok, rmc;
  logic [7:0]  paddr, lvl;
  logic [31:0] pwdata, rd;
  logic [11:0] pins;
  logic [1:0]  flt;
  int          fails, n_compared, cyc, olen, last_len, nint, gev;
  wire  [31:0] prdata;
  wire         pready, pslverr, ao, ac, ri, ro, open_cmd, close_cmd, fail_flag, gevt;
  wire  [1:0]  obj_status, cart_status;
  wire  [2:0]  gidx, geix;
  breaker_object_control #(.MS_CYCLES(4), .CNT_W(16)) u_breaker_object_control (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .obj_open_in(ao), .obj_close_in(ac), .cart_in_in(ri), .cart_out_in(ro),
    .ready_in(rdy), .sync_ok_in(sok), .local_open_in(pins[0]), .local_close_in(pins[1]),
    .remote_open_in(1'b0), .remote_close_in(rmc), .app_open_in(pins[2]),
    .app_close_in(pins[3]), .group_pulse_in(pins[11:4]), .group_level_in(lvl),
    .open_cmd(open_cmd), .close_cmd(close_cmd), .fail_flag(fail_flag),
    .obj_status(obj_status), .cart_status(cart_status), .setting_group_index(gidx),
    .group_event(gevt), .group_event_index(geix));
  breaker_model u_breaker_model (
    .clk(clk), .open_cmd(open_cmd), .close_cmd(close_cmd), .stuck(stuck), .slow(slow),
    .fault(flt), .aux_open(ao), .aux_close(ac), .rack_in(ri), .rack_out(ro));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Watchdog and pulse length monitor
  always @(posedge clk) begin
    cyc <= cyc + 1;
    gev <= gev + (gevt === 1'b1);
    nint <= nint + (obj_status === `BOC_ST_INTER);
    if (open_cmd === 1'b1)
      olen <= olen + 1;
    else if (olen != 0) begin
      last_len <= olen;
      olen <= 0;
    end
    if (cyc == 20000) begin
      fails++;
      report_and_stop;
    end
  end
  task report_and_stop;
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task run(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Held until pready is sampled high, as the bus requires
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Pins pass a synchroniser, so hold each pulse a few clocks
  task pulse(input logic [11:0] m);
    pins <= m;
    run(4);
    pins <= 12'h000;
    run(24);
  endtask
  task wst(input logic [1:0] s);
    for (int i = 0; i < 400 && obj_status !== s; i++) @(posedge clk);
    chk(obj_status, s);
  endtask
  initial begin
    int e;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, pins, lvl, flt, stuck, slow, sok, rmc} = '0;
    rdy = 1'b1;
    run(6);
    sys_rst <= 1'b0;
    rchk(`BOC_CTRL_OFS, 32'h0);
    rchk(`BOC_PULSE_OFS, 32'h00c800c8);
    rchk(`BOC_TIMES_OFS, 32'h271000c8);
    rchk(`BOC_GROUP_OFS, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    pulse(12'h001);
    rchk(`BOC_OPEN_CNT_OFS, 32'h0);
    pulse(12'h040);
    chk(gidx, 3'h0);
    apb(1'b1, `BOC_PULSE_OFS, 32'h00140014);
    apb(1'b1, `BOC_TIMES_OFS, 32'h00280002);
    apb(1'b1, `BOC_CTRL_OFS, 32'h19);
    e = nint;
    pulse(12'h001);
    wst(`BOC_ST_OPEN);
    chk(nint == e, 1'b1);
    // Model reacts a clock late, travels five, then sync and decode take four
    chk(last_len, 32'd10);
    rdy <= 1'b0;
    pulse(12'h002);
    chk(obj_status, `BOC_ST_OPEN);
    rdy <= 1'b1;
    slow <= 1'b1;
    pulse(12'h002);
    wst(`BOC_ST_INTER);
    wst(`BOC_ST_CLOSED);
    slow <= 1'b0;
    apb(1'b1, `BOC_CMD_OFS, 32'h1);
    run(24);
    chk(obj_status, `BOC_ST_CLOSED);
    apb(1'b1, `BOC_CTRL_OFS, 32'h1b);
    pulse(12'h001);
    chk(obj_status, `BOC_ST_CLOSED);
    pulse(12'h004);
    wst(`BOC_ST_OPEN);
    apb(1'b1, `BOC_CMD_OFS, 32'h2);
    wst(`BOC_ST_CLOSED);
    rchk(`BOC_OPEN_CNT_OFS, 32'h2);
    rchk(`BOC_CLOSE_CNT_OFS, 32'h2);
    stuck <= 1'b1;
    apb(1'b1, `BOC_CMD_OFS, 32'h1);
    for (int i = 0; i < 600 && fail_flag !== 1'b1; i++) @(posedge clk);
    chk(fail_flag, 1'b1);
    chk(last_len >= 75 && last_len <= 84, 1'b1);
    rchk(`BOC_OPEN_CNT_OFS, 32'h00010003);
    stuck <= 1'b0;
    apb(1'b1, `BOC_CMD_OFS, 32'h24);
    rchk(`BOC_OPEN_CNT_OFS, 32'h0);
    rchk(`BOC_CLOSE_CNT_OFS, 32'h0);
    chk(fail_flag, 1'b0);
    flt <= 2'h1;
    run(10);
    chk(obj_status, `BOC_ST_BAD);
    flt <= 2'h2;
    run(10);
    chk(cart_status, `BOC_ST_BAD);
    flt <= 2'h0;
    apb(1'b1, `BOC_GROUP_OFS, 32'h00ff);
    e = gev;
    pulse(12'h240);
    chk(gidx, 3'h2);
    chk(gev == e, 1'b1);
    apb(1'b1, `BOC_GROUP_OFS, 32'hffff);
    pulse(12'h800);
    chk(gidx, 3'h7);
    chk(gev == e + 1, 1'b1);
    chk(geix, 3'h7);
    apb(1'b1, `BOC_CMD_OFS, 32'h310);
    run(4);
    chk(gidx, 3'h7);
    apb(1'b1, `BOC_CTRL_OFS, 32'h3b);
    apb(1'b1, `BOC_CMD_OFS, 32'h310);
    run(4);
    chk(gidx, 3'h3);
    apb(1'b1, `BOC_CMD_OFS, 32'h108);
    run(4);
    chk(gidx, 3'h3);
    apb(1'b1, `BOC_CTRL_OFS, 32'h7b);
    apb(1'b1, `BOC_CMD_OFS, 32'h108);
    run(4);
    chk(gidx, 3'h1);
    apb(1'b1, `BOC_CTRL_OFS, 32'hfb);
    lvl <= 8'h10;
    run(12);
    chk(gidx, 3'h4);
    apb(1'b1, `BOC_CTRL_OFS, 32'hff);
    apb(1'b1, `BOC_CMD_OFS, 32'h2);
    rchk(`BOC_CLOSE_CNT_OFS, 32'h0);
    sok <= 1'b1;
    rmc <= 1'b1;
    run(4);
    rmc <= 1'b0;
    run(8);
    rchk(`BOC_CLOSE_CNT_OFS, 32'h1);
    report_and_stop;
  end
endmodule // tb_breaker_object_control
`default_nettype wire
